//--- vid_softstart_regs.vh
// Notes on behaviour
// R1: decode 6-bit voltage code to reference level, 0.8375 V up to 1.600 V.
// R2: sample the voltage code inputs six times per switching cycle.
// R3: on a code change, wait half a cycle, then step reference 12.5 mV.
// R4: if the difference changes during the half-cycle wait, cancel the step.
// R5: code more than one step away: step 12.5 mV six times per cycle.
// R6: processor should change the code one step at a time, at a controlled rate.
// R7: in shutdown all PWM outputs stay high impedance.
// R8: start soft start at once when bias, enable, logic enable and code allow.
// R9: no-load code enters shutdown; any other code afterward runs soft start.
// R10: after a no-load code wait two cycles, then shutdown trip level and PWM off.
// R11: a latched overvoltage shutdown is not cleared by no-load codes.
// R12: soft start ramps reference from zero to the programmed code level.
// R13: PWM stays high impedance until the ramp reaches the existing output level.
// R14: soft start begins with a 64-cycle delay, then ramps once per cycle.
// R15: first 640 ramp cycles step 25 mV, the rest step 12.5 mV.
// R16: 100 mV sense offset at ramp start falls to zero over 640 cycles.
// R17: power ok goes high once soft start completes inside the valid window.
// R18: reference is a counter in 12.5 mV units; 25 mV steps add two.
// R19: power ok low in shutdown or when disabled; overvoltage alone keeps it.
`ifndef VID_SOFTSTART_REGS_VH
`define VID_SOFTSTART_REGS_VH

`define CLK_FREQ_KHZ        200000
// 2 MHz keeps a whole soft start near 68k clocks; the sample divider rounds down to 16
`define SW_FREQ_KHZ         2000
`define SAMPLES_PER_CYCLE   6
`define SUB_CYC             (`CLK_FREQ_KHZ / (`SW_FREQ_KHZ * `SAMPLES_PER_CYCLE))
`define HALF_CYCLE_SAMPLES  2'h3
`define SS_DELAY_CYC        10'h040
`define SS_FAST_CYC         10'h280
`define SS_FAST_STEP        8'h02
`define OFFSET_START        4'h8
`define OFFSET_DEC_CYC      7'h50
`define NOLOAD_DELAY_CYC    2'h2
`define CODE_NOLOAD_A       6'h3F
`define CODE_NOLOAD_B       6'h3E
`define CODE_SPLIT          6'h15
`define LEVEL_LOW_BASE      8'h57
`define LEVEL_HIGH_BASE     8'h95
`define TRIP_PRE_ENABLE     2'h0
`define TRIP_SOFT_START     2'h1
`define TRIP_NORMAL         2'h2
`define TRIP_OV_LATCHED     2'h3

`endif

//--- cycle_timebase.v
`timescale 1ns/1ps
`include "vid_softstart_regs.vh"
module cycle_timebase (
  input  wire clk_in,
  input  wire nrst_in,
  output reg  sample_tick_out,
  output reg  cycle_tick_out
);
  reg [7:0] sub_q;
  reg [2:0] phase_q;

  // six sample ticks make one switching cycle
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sub_q           <= 8'h00;
      phase_q         <= 3'h0;
      sample_tick_out <= 1'b0;
      cycle_tick_out  <= 1'b0;
    end else begin
      sample_tick_out <= 1'b0;
      cycle_tick_out  <= 1'b0;
      if (sub_q == (`SUB_CYC - 1)) begin
        sub_q           <= 8'h00;
        sample_tick_out <= 1'b1;
        if (phase_q == (`SAMPLES_PER_CYCLE - 1)) begin
          phase_q        <= 3'h0;
          cycle_tick_out <= 1'b1;
        end else begin
          phase_q <= phase_q + 3'h1;
        end
      end else begin
        sub_q <= sub_q + 8'h01;
      end
    end
  end
endmodule

//--- vid_softstart_sequencer.v
`timescale 1ns/1ps
`include "vid_softstart_regs.vh"
module vid_softstart_sequencer (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire [5:0] voltage_code_input_in,
  input  wire       por_ok_in,
  input  wire       en_above_threshold_in,
  input  wire       logic_level_enable_in,
  input  wire       overvoltage_detect_in,
  input  wire [7:0] output_level_in,
  input  wire       output_window_ok_in,
  output reg  [7:0] ref_code_out,
  output reg  [3:0] sense_offset_out,
  output reg        pwm_drive_en_out,
  output reg  [1:0] trip_level_sel_out,
  output reg        overvoltage_trip_output_out,
  output reg        power_ok_output_out,
  output reg        soft_start_active_out
);
  localparam ST_SHUT   = 3'h0;
  localparam ST_DELAY  = 3'h1;
  localparam ST_RAMP   = 3'h2;
  localparam ST_RUN    = 3'h3;
  localparam ST_NOLOAD = 3'h4;

  // bit 0 of the code is the half_step_code_bit
  function [7:0] code_level;
    input [5:0] code;
    begin
      if (code < `CODE_SPLIT)
        code_level = `LEVEL_LOW_BASE - {2'b00, code};
      else
        code_level = `LEVEL_HIGH_BASE - {2'b00, code};
    end
  endfunction

  function is_noload;
    input [5:0] code;
    begin
      is_noload = (code == `CODE_NOLOAD_A) || (code == `CODE_NOLOAD_B);
    end
  endfunction

  wire sample_tick;
  wire cycle_tick;

  cycle_timebase u_timebase (
    .clk_in          (clk_in),
    .nrst_in         (nrst_in),
    .sample_tick_out (sample_tick),
    .cycle_tick_out  (cycle_tick)
  );

  reg [2:0] state_q;
  reg [5:0] code_q;
  reg [9:0] cyc_cnt_q;
  reg [6:0] off_cnt_q;
  reg [1:0] nl_cnt_q;
  reg       reached_q;
  reg       ov_latch_q;
  reg       pend_q;
  reg [1:0] pend_cnt_q;
  reg [8:0] pend_diff_q;

  wire       enables_ok;
  wire       noload;
  wire [7:0] target;
  wire [8:0] diff;
  wire       big_diff;
  wire [7:0] remain;
  wire [7:0] ramp_step;

  assign enables_ok = por_ok_in && en_above_threshold_in && logic_level_enable_in;
  assign noload     = is_noload(code_q);
  assign target     = code_level(code_q); // R1
  assign diff       = {1'b0, target} - {1'b0, ref_code_out};
  assign big_diff   = (diff != 9'h000) && (diff != 9'h001) && (diff != 9'h1FF);
  assign remain     = target - ref_code_out;
  // fast phase adds two units, clamped so the ramp never overshoots;
  // a code lowered below the reference halts the ramp and run steps it down
  assign ramp_step  = diff[8] ? 8'h00 :
                      (cyc_cnt_q < `SS_FAST_CYC) ?
                      ((remain < `SS_FAST_STEP) ? remain : `SS_FAST_STEP) : // R15 R18
                      ((remain != 8'h00) ? 8'h01 : 8'h00);

  // code sampled only on sample ticks, six per cycle
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      code_q <= `CODE_NOLOAD_A;
    else if (sample_tick)
      code_q <= voltage_code_input_in; // R2
  end

  // overvoltage latch: cleared only by dropping an enable source, never by codes
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      ov_latch_q <= 1'b0;
    else if (overvoltage_detect_in)
      ov_latch_q <= 1'b1;
    else if (!enables_ok)
      ov_latch_q <= 1'b0; // R11
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q                     <= ST_SHUT;
      cyc_cnt_q                   <= 10'h000;
      off_cnt_q                   <= 7'h00;
      nl_cnt_q                    <= 2'h0;
      reached_q                   <= 1'b0;
      pend_q                      <= 1'b0;
      pend_cnt_q                  <= 2'h0;
      pend_diff_q                 <= 9'h000;
      ref_code_out                <= 8'h00;
      sense_offset_out            <= 4'h0;
      pwm_drive_en_out            <= 1'b0;
      trip_level_sel_out          <= `TRIP_PRE_ENABLE;
      overvoltage_trip_output_out <= 1'b0;
      power_ok_output_out         <= 1'b0;
      soft_start_active_out       <= 1'b0;
    end else begin
      overvoltage_trip_output_out <= ov_latch_q || overvoltage_detect_in;
      if (!enables_ok) begin
        // any enable source lost: straight to shutdown
        state_q               <= ST_SHUT;
        pwm_drive_en_out      <= 1'b0; // R7
        power_ok_output_out   <= 1'b0; // R19
        soft_start_active_out <= 1'b0;
        sense_offset_out      <= 4'h0;
        ref_code_out          <= 8'h00;
        trip_level_sel_out    <= `TRIP_PRE_ENABLE;
      end else if (ov_latch_q || overvoltage_detect_in) begin
        // switching stops until an enable cycles; power ok left as it is
        state_q               <= ST_SHUT;
        pwm_drive_en_out      <= 1'b0;
        soft_start_active_out <= 1'b0;
        trip_level_sel_out    <= `TRIP_OV_LATCHED; // R19
      end else begin
        case (state_q)
          ST_SHUT: begin
            pwm_drive_en_out    <= 1'b0; // R7
            power_ok_output_out <= 1'b0; // R19
            ref_code_out        <= 8'h00;
            if (!noload) begin
              state_q               <= ST_DELAY; // R8 R9
              cyc_cnt_q             <= 10'h000;
              soft_start_active_out <= 1'b1;
              trip_level_sel_out    <= `TRIP_SOFT_START;
            end
          end
          ST_DELAY: begin
            if (noload) begin
              state_q <= ST_SHUT;
              soft_start_active_out <= 1'b0;
              trip_level_sel_out    <= `TRIP_PRE_ENABLE;
            end else if (cycle_tick) begin
              if (cyc_cnt_q == (`SS_DELAY_CYC - 10'h001)) begin
                state_q          <= ST_RAMP; // R14
                cyc_cnt_q        <= 10'h000;
                off_cnt_q        <= 7'h00;
                reached_q        <= 1'b0;
                sense_offset_out <= `OFFSET_START; // R16
              end else begin
                cyc_cnt_q <= cyc_cnt_q + 10'h001;
              end
            end
          end
          ST_RAMP: begin
            if (!reached_q && (ref_code_out >= output_level_in)) begin
              reached_q        <= 1'b1;
              pwm_drive_en_out <= 1'b1; // R13
            end
            if (noload) begin
              state_q  <= ST_NOLOAD;
              nl_cnt_q <= 2'h0;
              power_ok_output_out <= 1'b0; // R19
            end else if (cycle_tick) begin
              ref_code_out <= ref_code_out + ramp_step; // R12 R15 R18
              if (cyc_cnt_q != `SS_FAST_CYC)
                cyc_cnt_q <= cyc_cnt_q + 10'h001;
              if (sense_offset_out != 4'h0) begin
                if (off_cnt_q == (`OFFSET_DEC_CYC - 7'h01)) begin
                  off_cnt_q        <= 7'h00;
                  sense_offset_out <= sense_offset_out - 4'h1; // R16
                end else begin
                  off_cnt_q <= off_cnt_q + 7'h01;
                end
              end
              if ((diff[8] || (remain == 8'h00)) && (sense_offset_out == 4'h0) && reached_q) begin
                state_q               <= ST_RUN;
                soft_start_active_out <= 1'b0;
                trip_level_sel_out    <= `TRIP_NORMAL;
                pend_q                <= 1'b0;
              end
            end
          end
          ST_RUN: begin
            pwm_drive_en_out <= 1'b1;
            if (output_window_ok_in)
              power_ok_output_out <= 1'b1; // R17
            if (noload) begin
              state_q             <= ST_NOLOAD;
              nl_cnt_q            <= 2'h0;
              power_ok_output_out <= 1'b0; // R19
            end else if (sample_tick) begin
              if (big_diff) begin
                pend_q <= 1'b0;
                ref_code_out <= diff[8] ? ref_code_out - 8'h01
                                        : ref_code_out + 8'h01; // R5
              end else if (diff == 9'h000) begin
                pend_q <= 1'b0;
              end else if (!pend_q) begin
                pend_q      <= 1'b1; // R3
                pend_cnt_q  <= 2'h1;
                pend_diff_q <= diff;
              end else if (diff != pend_diff_q) begin
                pend_q <= 1'b0; // R4
              end else if (pend_cnt_q == `HALF_CYCLE_SAMPLES) begin
                pend_q <= 1'b0;
                ref_code_out <= diff[8] ? ref_code_out - 8'h01
                                        : ref_code_out + 8'h01; // R3
              end else begin
                pend_cnt_q <= pend_cnt_q + 2'h1;
              end
            end
          end
          ST_NOLOAD: begin
            // pwm drive keeps its state for two cycles before shutdown
            if (cycle_tick) begin
              if (nl_cnt_q == (`NOLOAD_DELAY_CYC - 2'h1)) begin
                state_q               <= ST_SHUT; // R10
                pwm_drive_en_out      <= 1'b0;
                trip_level_sel_out    <= `TRIP_PRE_ENABLE;
                soft_start_active_out <= 1'b0;
                sense_offset_out      <= 4'h0;
              end else begin
                nl_cnt_q <= nl_cnt_q + 2'h1;
              end
            end
          end
          default: begin
            state_q <= ST_SHUT;
          end
        endcase
      end
    end
  end
endmodule

//--- vid_source.sv
`timescale 1ns/1ps
module vid_source (
  input  wire        clk_in,
  output logic [5:0] code_out
);
  // starts on a no-load code so nothing powers up before the bench asks
  initial code_out = 6'h3F;
  // the code moves only when asked, one whole code at a time, off the sampling edge
  task automatic put(input logic [5:0] c);
    @(negedge clk_in);
    code_out = c;
  endtask
endmodule

//--- vid_softstart_properties.sv
`timescale 1ns/1ps
module vid_softstart_checker (
  input wire       clk_in,
  input wire       nrst_in,
  input wire [5:0] voltage_code_input_in,
  input wire       por_ok_in,
  input wire       en_above_threshold_in,
  input wire       logic_level_enable_in,
  input wire       overvoltage_detect_in,
  input wire [7:0] output_level_in,
  input wire       output_window_ok_in,
  input wire [7:0] ref_code_out,
  input wire [3:0] sense_offset_out,
  input wire       pwm_drive_en_out,
  input wire [1:0] trip_level_sel_out,
  input wire       overvoltage_trip_output_out,
  input wire       power_ok_output_out,
  input wire       soft_start_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire en_all = por_ok_in && en_above_threshold_in && logic_level_enable_in;
  sequence s_start; $rose(soft_start_active_out); endsequence
  sequence s_idle_ref; (ref_code_out == 8'h00 && !pwm_drive_en_out) [*8]; endsequence
  property p_start_delay; s_start |-> trip_level_sel_out == 2'h1 ##0 s_idle_ref; endproperty
  a_start_delay:
    assert property (p_start_delay) else $error("reference moved without start delay");
  property p_shut_hiz; trip_level_sel_out == 2'h0 |-> !pwm_drive_en_out; endproperty
  a_shut_hiz:
    assert property (p_shut_hiz) else $error("pwm driven in shutdown");
  property p_ov_act;
    overvoltage_detect_in && en_all
      |=> !pwm_drive_en_out && overvoltage_trip_output_out && trip_level_sel_out == 2'h3;
  endproperty
  a_ov_act:
    assert property (p_ov_act) else $error("overvoltage not acted on");
  property p_ov_pok;
    $rose(overvoltage_trip_output_out) |-> power_ok_output_out == $past(power_ok_output_out);
  endproperty
  a_ov_pok:
    assert property (p_ov_pok) else $error("power ok moved on overvoltage");
  property p_disable;
    !en_all |=> !power_ok_output_out && !pwm_drive_en_out && ref_code_out == 8'h00
      && !soft_start_active_out;
  endproperty
  a_disable:
    assert property (p_disable) else $error("outputs alive while disabled");
  property p_ramp_step;
    soft_start_active_out && $past(soft_start_active_out)
      && ref_code_out != $past(ref_code_out)
      |-> (ref_code_out - $past(ref_code_out)) inside {8'h01, 8'h02};
  endproperty
  a_ramp_step:
    assert property (p_ramp_step) else $error("bad soft start step");
  property p_offset; sense_offset_out <= 4'h8; endproperty
  a_offset:
    assert property (p_offset) else $error("sense offset above start value");
  property p_pwm_reach; $rose(pwm_drive_en_out) |-> $past(ref_code_out >= output_level_in);
  endproperty
  a_pwm_reach:
    assert property (p_pwm_reach) else $error("pwm enabled below output level");
  property p_pok_run;
    $rose(power_ok_output_out) |-> trip_level_sel_out == 2'h2 && !soft_start_active_out
      && $past(output_window_ok_in);
  endproperty
  a_pok_run:
    assert property (p_pok_run) else $error("power ok before soft start done");
endmodule
bind vid_softstart_sequencer vid_softstart_checker vid_softstart_checker_i (.*);

//--- tb_top.sv
`timescale 1ns/1ps
`include "vid_softstart_regs.vh"
module tb_top;
  localparam int CYC = `SUB_CYC * `SAMPLES_PER_CYCLE;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       por, en, ll, ov, win;
  logic [7:0] lvl, ref_code, hi;
  logic [5:0] code;
  logic [3:0] offs;
  logic [1:0] trip;
  logic       pwm, overvoltage_trip_output, pok, ssa;
  int         n_errors = 0;
  int         checks = 0;
  int         cyc = 0;
  int         i;
  // rows: code, por, enable, logic enable, expected soft start
  logic [9:0] rows [6] = '{10'h3FE, 10'h3EE, 10'h1A6, 10'h1AA, 10'h1AC, 10'h1AF};
  always #2.5 clk_in = ~clk_in;
  vid_source vid_source_i (.clk_in, .code_out(code));
  vid_softstart_sequencer vid_softstart_sequencer_i (
    .clk_in, .nrst_in, .voltage_code_input_in(code), .por_ok_in(por),
    .en_above_threshold_in(en), .logic_level_enable_in(ll), .overvoltage_detect_in(ov),
    .output_level_in(lvl), .output_window_ok_in(win), .ref_code_out(ref_code),
    .sense_offset_out(offs), .pwm_drive_en_out(pwm), .trip_level_sel_out(trip),
    .overvoltage_trip_output_out(overvoltage_trip_output), .power_ok_output_out(pok),
    .soft_start_active_out(ssa));
  task automatic tally_and_finish();
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one full soft start, one restart to first switching and the run checks fit below this
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // start delay plus two ramp steps fit well inside this bound
  task automatic to_pwm();
    for (i = 0; i < 70 * CYC && pwm !== 1'b1; i++) tick(1);
  endtask
  // run follows the last offset step, 641 cycles into the ramp
  task automatic to_run();
    for (i = 0; i < 660 * CYC && ssa !== 1'b0; i++) tick(1);
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      tick(1);
      if (ref_code > hi) hi = ref_code;
    end
  endtask
  initial begin
    {por, en, ll, ov, win} = 5'h00;
    lvl = 8'h03;
    tick(3);
    nrst_in = 1'b1;
    for (int r = 0; r < 6; r++) begin
      vid_source_i.put(rows[r][9:4]);
      {por, en, ll} = rows[r][3:1];
      tick(`SUB_CYC + 4);
      chk(ssa, rows[r][0]);
      chk(trip, rows[r][0]);
    end
    to_pwm();
    chk(ref_code, 8'h04);
    chk(offs, 4'h8);
    to_run();
    chk({offs, ref_code}, 12'h07B);
    chk({trip, pok}, 8'h04);
    win = 1'b1;
    tick(2);
    chk(pok, 8'h01);
    vid_source_i.put(6'h1B);
    tick(2 * `SUB_CYC);
    chk(ref_code, 8'h7B);
    tick(4 * `SUB_CYC);
    chk(ref_code, 8'h7A);
    hi = ref_code;
    vid_source_i.put(6'h1A);
    watch(2 * `SUB_CYC);
    vid_source_i.put(6'h1C);
    watch(10 * `SUB_CYC);
    chk(hi, 8'h7A);
    chk(ref_code, 8'h79);
    vid_source_i.put(6'h1F);
    tick(3 * `SUB_CYC + 2);
    chk(ref_code, 8'h77);
    tick(5 * `SUB_CYC);
    chk({pok, ref_code}, 12'h176);
    ov = 1'b1;
    tick(2);
    ov = 1'b0;
    chk({overvoltage_trip_output, pwm, trip}, 8'h0B);
    chk(pok, 8'h01);
    vid_source_i.put(6'h3F);
    tick(3 * CYC);
    vid_source_i.put(6'h1A);
    tick(3 * CYC);
    chk({overvoltage_trip_output, trip}, 8'h07);
    ll = 1'b0;
    tick(2);
    chk({overvoltage_trip_output, pok, ref_code}, 12'h000);
    ll = 1'b1;
    tick(`SUB_CYC);
    chk(ssa, 8'h01);
    to_pwm();
    vid_source_i.put(6'h3F);
    tick(6 * `SUB_CYC);
    chk({pok, pwm}, 8'h01);
    tick(3 * CYC);
    chk({pwm, trip, ssa}, 8'h00);
    vid_source_i.put(6'h1A);
    tick(`SUB_CYC + 4);
    chk(ssa, 8'h01);
    tally_and_finish();
  end
endmodule
